//--- common/ext_mem_pkg.sv
// package for the external memory pin control block: types and constants
`default_nettype none
package ext_mem_pkg;

	// clock source strap encodings
	localparam logic [1:0] CLKSEL_EXT = 2'h0;
	localparam logic [1:0] CLKSEL_CPU4 = 2'h1;
	localparam logic [1:0] CLKSEL_CPU6 = 2'h2;
	localparam logic [1:0] CLKSEL_RSVD = 2'h3;

	// divide ratios of the cpu-derived sources
	localparam int CPU4_RATIO = 4;
	localparam int CPU6_RATIO = 6;

	// divided output clock ratio codes
	localparam logic [1:0] DIV_BY1 = 2'h0;
	localparam logic [1:0] DIV_BY2 = 2'h1;
	localparam logic [1:0] DIV_BY4 = 2'h2;

	// external address layout: doubleword lines 3 to 22
	localparam int ADDR_LO = 3;
	localparam int ADDR_HI = 22;
	localparam int ADDR_W = ADDR_HI - ADDR_LO + 1;

	// space decode field of the word address
	localparam int SPACE_LO = 28;
	localparam int SPACE_HI = 31;

	// space whose dedicated fifo output enable exists
	localparam int FIFO_SPACE = 3;
	localparam int NUM_SPACES = 4;

	// strap sample field on the external address
	localparam int STRAP_LO = 19;

	// reset values
	localparam logic [1:0] CLKSEL_RESET = 2'h0;
	localparam logic SDRAM_CKE_RESET = 1'b1;

	// attached memory type of an access
	typedef enum logic [2:0]
	{
		MEM_ASYNC = 3'b001,
		MEM_SDRAM = 3'b010,
		MEM_SYNC = 3'b100
	} mem_kind_t;

	// sdram command carried on the three shared pins (active high here)
	typedef struct packed
	{
		logic row;
		logic col;
		logic wr;
	} sdram_cmd_t;

	// access request from the transfer engine
	typedef struct packed
	{
		logic [31:0] word_addr;
		mem_kind_t kind;
		logic write;
	} access_req_t;

	// shared strobe pins, active high inside the block
	typedef struct packed
	{
		logic rd_strobe;
		logic out_en;
		logic wr_strobe;
	} strobe_pins_t;

endpackage : ext_mem_pkg

`default_nettype wire

//--- rtl/ext_mem_pin_control.sv
// pin-level control and clocking of the 64-bit external memory interface
//
// Behaviour
// [R01] strap selects clock: external, cpu/4, cpu/6
// [R02] external clock used when nothing strapped
// [R03] divided output clock: by one, two, four
// [R04] full-rate output clock equals selected source
// [R05] read pin: async read, sdram column, sync
// [R06] select bit: clear address strobe, set read
// [R07] oe pin: async oe, sdram row, sync oe
// [R08] we pin: async, sdram, sync write enables
// [R09] sdram clock enable, else general-purpose output
// [R10] dedicated fifo output enable for space three
// [R11] async memory ready input gates completion
// [R12] doubleword address lines three to twenty-two
// [R13] strap codes 00 ext, 01 /4, 10 /6
// [R14] one space enable from address bits 28-31
// [R15] hold strobe while ready is inactive
`timescale 1ns/100ps
`default_nettype none

module ext_mem_pin_control
#(
	parameter int ADDR_WIDTH = ext_mem_pkg::ADDR_W,
	parameter int SPACES = ext_mem_pkg::NUM_SPACES
)
(
	input wire logic I_CLK,
	input wire logic I_RESETN,
	// cpu-rate enable pulse; the cpu-derived sources divide it down
	input wire logic i_cpu_tick,
	// external input clock, sampled as a level in this domain
	input wire logic i_external_input_clock,
	// strap levels present on the address pins during reset
	input wire logic [1:0] i_strap,
	// divided output clock ratio code
	input wire logic [1:0] i_div_sel,
	// strobe function select of the space secondary control
	input wire logic [SPACES-1:0] i_strobe_function_select,
	// sdram presence and requested clock enable / gp level
	input wire logic i_sdram_present,
	input wire logic i_sdram_clk_en_req,
	input wire logic i_gp_out,
	// access request
	input wire logic i_req_valid,
	input wire ext_mem_pkg::access_req_t i_req,
	input wire ext_mem_pkg::sdram_cmd_t i_sdram_cmd,
	output logic o_req_ready,
	// asynchronous ready from the memory
	input wire logic i_async_ready_in,
	// pins
	output logic O_MEM_CLOCK_OUT_FULL,
	output logic O_MEM_CLOCK_OUT_DIV,
	output logic [1:0] O_CLK_SEL,
	output ext_mem_pkg::strobe_pins_t O_STROBES_N,
	output logic O_SDRAM_CLK_EN,
	output logic O_FIFO_SPACE_OUT_EN_N,
	output logic [SPACES-1:0] O_SPACE_SEL_N,
	output logic [ADDR_WIDTH-1:0] O_EXTERNAL_ADDR
);
	import ext_mem_pkg::*;

	// ****************************************************************
	// helper functions
	// ****************************************************************

	// one-hot space enable from the word address; only one set at a time
	function automatic logic [SPACES-1:0] space_decode(input logic [31:0] a);
		logic [SPACES-1:0] d;
		d = '0;
		if (a[SPACE_HI:SPACE_LO] < 4'(SPACES))
			d[a[SPACE_LO+1:SPACE_LO]] = 1'b1; // see [R14]
		return d;
	endfunction : space_decode

	// ****************************************************************
	// clock source selection
	// ****************************************************************

	logic [1:0] clk_sel_reg; // strapped source code
	logic strap_taken_reg; // strap caught once after release
	logic [2:0] cpu_cnt_reg; // cpu tick divider
	logic src_tick; // one-cycle pulse at the selected source rate
	logic ext_q_reg; // previous external clock sample
	logic ext_rise;
	logic ext_fall;
	logic half_tick; // pulse at every edge of the selected source

	// the strap is caught on the first clock after reset release,
	// so the pins have settled before the choice is frozen
	always_ff @(posedge I_CLK)
	begin
		if (!I_RESETN)
		begin
			clk_sel_reg <= CLKSEL_RESET; // see [R02]
			strap_taken_reg <= 1'b0;
		end
		else if (!strap_taken_reg)
		begin
			strap_taken_reg <= 1'b1;
			// reserved code falls back to the external clock
			if (i_strap == CLKSEL_RSVD)
				clk_sel_reg <= CLKSEL_EXT; // see [R02]
			else
				clk_sel_reg <= i_strap; // see [R01] see [R13]
		end
	end

	// external clock edge detect; the sample follows the pin through reset
	// so a clock that is high at release gives no false edge
	always_ff @(posedge I_CLK)
	begin
		ext_q_reg <= i_external_input_clock;
	end
	assign ext_rise = i_external_input_clock & ~ext_q_reg;
	assign ext_fall = ~i_external_input_clock & ext_q_reg;

	// cpu divider wraps at four or six depending on the strap
	always_ff @(posedge I_CLK)
	begin
		if (!I_RESETN)
			cpu_cnt_reg <= 3'h0;
		else if (i_cpu_tick)
		begin
			if ((clk_sel_reg == CLKSEL_CPU4 && cpu_cnt_reg == 3'(CPU4_RATIO - 1)) ||
				(clk_sel_reg == CLKSEL_CPU6 && cpu_cnt_reg == 3'(CPU6_RATIO - 1)))
				cpu_cnt_reg <= 3'h0;
			else
				cpu_cnt_reg <= cpu_cnt_reg + 3'h1;
		end
	end

	// src_tick once a source period, half_tick at both source edges;
	// toggling on half ticks keeps the full output clock at the source rate
	always_comb
	begin
		unique case (clk_sel_reg)
			CLKSEL_CPU4:
			begin
				src_tick = i_cpu_tick && cpu_cnt_reg == 3'h0; // see [R01]
				half_tick = i_cpu_tick &&
					(cpu_cnt_reg == 3'h0 || cpu_cnt_reg == 3'(CPU4_RATIO / 2));
			end
			CLKSEL_CPU6:
			begin
				src_tick = i_cpu_tick && cpu_cnt_reg == 3'h0; // see [R01]
				half_tick = i_cpu_tick &&
					(cpu_cnt_reg == 3'h0 || cpu_cnt_reg == 3'(CPU6_RATIO / 2));
			end
			default:
			begin
				src_tick = ext_rise; // see [R02]
				half_tick = ext_rise | ext_fall; // see [R02]
			end
		endcase
	end

	// ****************************************************************
	// output clocks
	// ****************************************************************

	logic [1:0] div_cnt_reg; // source edge (half tick) count for the divided clock
	logic full_clk_reg;
	logic div_clk_reg;

	// full clock toggles at every source edge: same frequency as the source
	always_ff @(posedge I_CLK)
	begin
		if (!I_RESETN)
			full_clk_reg <= 1'b0;
		else if (half_tick)
			full_clk_reg <= ~full_clk_reg; // see [R04]
	end

	// divided clock toggles every 1, 2 or 4 source edges
	always_ff @(posedge I_CLK)
	begin
		if (!I_RESETN)
		begin
			div_cnt_reg <= 2'h0;
			div_clk_reg <= 1'b0;
		end
		else if (half_tick)
		begin
			if ((i_div_sel == DIV_BY2 && div_cnt_reg != 2'h1) ||
				(i_div_sel == DIV_BY4 && div_cnt_reg != 2'h3))
				div_cnt_reg <= div_cnt_reg + 2'h1;
			else
			begin
				div_cnt_reg <= 2'h0;
				div_clk_reg <= ~div_clk_reg; // see [R03]
			end
		end
	end

	assign O_MEM_CLOCK_OUT_FULL = full_clk_reg;
	assign O_MEM_CLOCK_OUT_DIV = div_clk_reg;
	assign O_CLK_SEL = clk_sel_reg;

	// ****************************************************************
	// access sequencer
	// ****************************************************************

	// idle, strobe active, wait for async ready
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_STROBE = 3'b010,
		ST_WAIT = 3'b100
	} acc_state_t;

	acc_state_t state_reg;
	access_req_t req_reg; // captured access
	sdram_cmd_t cmd_reg; // captured sdram command
	strobe_pins_t strobe_reg; // active-high strobe levels
	logic [SPACES-1:0] space_reg; // active-high space enables
	logic fifo_oe_reg;
	logic [ADDR_WIDTH-1:0] addr_reg;

	// accept a request only when idle and on a source tick
	assign o_req_ready = state_reg == ST_IDLE && src_tick;

	// state moves on source ticks so strobes align with the output clock
	always_ff @(posedge I_CLK)
	begin
		if (!I_RESETN)
		begin
			state_reg <= ST_IDLE;
			req_reg <= '0;
			cmd_reg <= '0;
		end
		else if (src_tick)
		begin
			unique case (state_reg)
				ST_IDLE:
					if (i_req_valid)
					begin
						req_reg <= i_req;
						cmd_reg <= i_sdram_cmd;
						state_reg <= ST_STROBE;
					end
				ST_STROBE:
					// async accesses need ready before they can end
					if (req_reg.kind == MEM_ASYNC && !i_async_ready_in)
						state_reg <= ST_WAIT; // see [R11] see [R15]
					else
						state_reg <= ST_IDLE;
				ST_WAIT:
					if (i_async_ready_in)
						state_reg <= ST_IDLE; // see [R11]
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	// pin functions per memory type; strobes stay on through the wait
	always_ff @(posedge I_CLK)
	begin
		if (!I_RESETN)
		begin
			strobe_reg <= '0;
			space_reg <= '0;
			fifo_oe_reg <= 1'b0;
			addr_reg <= '0;
		end
		else if (state_reg == ST_IDLE)
		begin
			strobe_reg <= '0;
			space_reg <= '0;
			fifo_oe_reg <= 1'b0;
		end
		else
		begin
			space_reg <= space_decode(req_reg.word_addr); // see [R14]
			// word address bit 0 is doubleword line 3
			addr_reg <= req_reg.word_addr[ADDR_WIDTH-1:0]; // see [R12]
			unique case (req_reg.kind)
				MEM_SDRAM:
				begin
					strobe_reg.rd_strobe <= cmd_reg.col; // see [R05]
					strobe_reg.out_en <= cmd_reg.row; // see [R07]
					strobe_reg.wr_strobe <= cmd_reg.wr; // see [R08]
				end
				MEM_SYNC:
				begin
					// address strobe on every access when select is clear,
					// read enable only on reads when set
					if (i_strobe_function_select[req_reg.word_addr[SPACE_LO+1:SPACE_LO]])
						strobe_reg.rd_strobe <= !req_reg.write; // see [R06]
					else
						strobe_reg.rd_strobe <= 1'b1; // see [R06]
					strobe_reg.out_en <= !req_reg.write; // see [R07]
					strobe_reg.wr_strobe <= req_reg.write; // see [R08]
					fifo_oe_reg <= !req_reg.write &&
						space_decode(req_reg.word_addr) == SPACES'(1 << FIFO_SPACE); // see [R10]
				end
				default:
				begin
					strobe_reg.rd_strobe <= !req_reg.write; // see [R05] see [R15]
					strobe_reg.out_en <= !req_reg.write; // see [R07]
					strobe_reg.wr_strobe <= req_reg.write; // see [R08]
				end
			endcase
		end
	end

	// ****************************************************************
	// pin drive
	// ****************************************************************

	logic sdram_cke_reg;

	// clock enable for self-refresh, or a plain output without sdram
	always_ff @(posedge I_CLK)
	begin
		if (!I_RESETN)
			sdram_cke_reg <= SDRAM_CKE_RESET;
		else if (i_sdram_present)
			sdram_cke_reg <= i_sdram_clk_en_req; // see [R09]
		else
			sdram_cke_reg <= i_gp_out; // see [R09]
	end

	assign O_SDRAM_CLK_EN = sdram_cke_reg;
	assign O_STROBES_N = ~strobe_reg;
	assign O_SPACE_SEL_N = ~space_reg;
	assign O_FIFO_SPACE_OUT_EN_N = ~fifo_oe_reg;
	assign O_EXTERNAL_ADDR = addr_reg;

endmodule : ext_mem_pin_control

`default_nettype wire

//--- verification/ext_mem_pin_control_properties.sv
// checker of the memory pin control block ports
`timescale 1ns/100ps
`default_nettype none
module ext_mem_pin_control_props
import ext_mem_pkg::*;
#(
	parameter int ADDR_WIDTH = 20,
	parameter int SPACES = 4
)
(
	input wire logic I_CLK,
	input wire logic I_RESETN,
	input wire logic [1:0] i_strap,
	input wire logic i_sdram_present,
	input wire logic i_sdram_clk_en_req,
	input wire logic i_gp_out,
	input wire logic i_req_valid,
	input wire ext_mem_pkg::access_req_t i_req,
	input wire logic o_req_ready,
	input wire logic O_MEM_CLOCK_OUT_FULL,
	input wire logic O_MEM_CLOCK_OUT_DIV,
	input wire logic [1:0] O_CLK_SEL,
	input wire ext_mem_pkg::strobe_pins_t O_STROBES_N,
	input wire logic O_SDRAM_CLK_EN,
	input wire logic O_FIFO_SPACE_OUT_EN_N,
	input wire logic [SPACES-1:0] O_SPACE_SEL_N,
	input wire logic [ADDR_WIDTH-1:0] O_EXTERNAL_ADDR
);
	import ext_mem_pkg::*;
	logic take;
	logic [ADDR_WIDTH-1:0] addr_reg; // address of the last taken access
	logic cke_reg; // level the clock enable pin should show now
	assign take = i_req_valid && o_req_ready;
	// keeps the expectations one cycle behind their cause
	always_ff @(posedge I_CLK)
	begin
		if (take)
			addr_reg <= i_req.word_addr[ADDR_WIDTH-1:0];
		cke_reg <= i_sdram_present ? i_sdram_clk_en_req : i_gp_out;
	end
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RESETN);
	strap_latch_a:
	assert property ($rose(I_RESETN) && i_strap != CLKSEL_RSVD |=> O_CLK_SEL == $past(i_strap))
	else $error("strap not latched");
	clk_sel_legal_a:
	assert property (O_CLK_SEL != CLKSEL_RSVD) else $error("reserved clock select");
	div_follows_a:
	assert property ($changed(O_MEM_CLOCK_OUT_DIV) |-> $changed(O_MEM_CLOCK_OUT_FULL))
	else $error("divided clock off its source");
	one_space_a:
	assert property ($onehot0(~O_SPACE_SEL_N)) else $error("two spaces enabled");
	space_decode_a:
	assert property (take && i_req.word_addr[31:28] == 4'h0 |-> ##[1:3] !O_SPACE_SEL_N[0])
	else $error("space zero not enabled");
	addr_lines_a:
	assert property (take |-> ##[1:3] O_EXTERNAL_ADDR == addr_reg) else $error("address wrong");
	fifo_space_a:
	assert property (!O_FIFO_SPACE_OUT_EN_N |-> !O_SPACE_SEL_N[FIFO_SPACE])
	else $error("fifo enable outside space three");
	cke_level_a:
	assert property ($past(I_RESETN) |-> O_SDRAM_CLK_EN == cke_reg) else $error("clock enable wrong");
	idle_at_start_a:
	assert property ($rose(I_RESETN) |-> O_STROBES_N == 3'h7 && O_SPACE_SEL_N == '1)
	else $error("strobes active after reset");
	cover property (take && i_req.kind == MEM_ASYNC);
	cover property (!O_FIFO_SPACE_OUT_EN_N);
	cover property (!O_SDRAM_CLK_EN);
endmodule : ext_mem_pin_control_props
bind ext_mem_pin_control ext_mem_pin_control_props #(.ADDR_WIDTH(ADDR_WIDTH), .SPACES(SPACES)) u_props
(.I_CLK, .I_RESETN, .i_strap, .i_sdram_present, .i_sdram_clk_en_req, .i_gp_out, .i_req_valid,
.i_req, .o_req_ready, .O_MEM_CLOCK_OUT_FULL, .O_MEM_CLOCK_OUT_DIV, .O_CLK_SEL, .O_STROBES_N,
.O_SDRAM_CLK_EN, .O_FIFO_SPACE_OUT_EN_N, .O_SPACE_SEL_N, .O_EXTERNAL_ADDR);
`default_nettype wire

//--- verification/async_mem_model.sv
// slow asynchronous memory that stretches accesses through its ready line
`timescale 1ns/100ps
`default_nettype none
module async_mem_model
import ext_mem_pkg::*;
(
	input wire logic I_CLK,
	input wire ext_mem_pkg::strobe_pins_t i_strobes_n,
	input wire logic [7:0] i_wait,
	output logic o_ready
);
	logic [7:0] cnt_reg; // cycles the current strobe has been active
	// counts while strobed, saturating so a stuck strobe cannot wrap
	always_ff @(posedge I_CLK)
	begin
		if (i_strobes_n == 3'h7)
			cnt_reg <= 8'h00;
		else if (cnt_reg != 8'hff)
			cnt_reg <= cnt_reg + 8'h01;
	end
	// pulled up while idle, low until the wait is over
	assign o_ready = (i_strobes_n == 3'h7) || (cnt_reg >= i_wait);
endmodule : async_mem_model
`default_nettype wire

//--- verification/test_ext_mem_pin_control.sv
// self-checking bench of the memory pin control block
`timescale 1ns/100ps
`default_nettype none
module test_ext_mem_pin_control;
	import ext_mem_pkg::*;
	logic clk = 0, rst_n = 0, tick = 0, ext_clk = 0, pres = 0, cke_req = 0, gp = 0, req_v = 0;
	logic [1:0] strap = 0, div_sel = 0, clk_sel;
	logic [3:0] fsel = 0, sp_n;
	access_req_t req = '0;
	sdram_cmd_t cmd = '0;
	strobe_pins_t stb_n;
	logic rdy, mrdy, full, divc, cke, fifo_n;
	logic [19:0] addr;
	logic [7:0] wt = 0;
	int num_errors = 0, checked = 0;
	initial forever #4 clk = ~clk;
	logic [1:0] ext_cnt = 0; // paces the external clock
	// external clock of six core cycles, moved on the rising edge like every input
	always @(posedge clk)
	begin
		ext_cnt <= (ext_cnt == 2'h2) ? 2'h0 : ext_cnt + 2'h1;
		if (ext_cnt == 2'h2)
			ext_clk <= ~ext_clk;
	end
	always @(posedge clk) tick <= ~tick;
	ext_mem_pin_control dut (.I_CLK(clk), .I_RESETN(rst_n), .i_cpu_tick(tick),
		.i_external_input_clock(ext_clk), .i_strap(strap), .i_div_sel(div_sel),
		.i_strobe_function_select(fsel), .i_sdram_present(pres), .i_sdram_clk_en_req(cke_req),
		.i_gp_out(gp), .i_req_valid(req_v), .i_req(req), .i_sdram_cmd(cmd), .o_req_ready(rdy),
		.i_async_ready_in(mrdy), .O_MEM_CLOCK_OUT_FULL(full), .O_MEM_CLOCK_OUT_DIV(divc),
		.O_CLK_SEL(clk_sel), .O_STROBES_N(stb_n), .O_SDRAM_CLK_EN(cke),
		.O_FIFO_SPACE_OUT_EN_N(fifo_n), .O_SPACE_SEL_N(sp_n), .O_EXTERNAL_ADDR(addr));
	async_mem_model mem (.I_CLK(clk), .i_strobes_n(stb_n), .i_wait(wt), .o_ready(mrdy));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic final_report;
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report
	// straps stay on the pins past the sampling edge
	task automatic reset_to(input logic [1:0] s);
		@(posedge clk);
		rst_n <= 0;
		strap <= s;
		repeat (4) @(posedge clk);
		rst_n <= 1;
		repeat (2) @(posedge clk);
	endtask : reset_to
	// per is the source tick period in cycles, 0 for the external clock
	task automatic clocks(input logic [1:0] s, input int per);
		int f, d, e;
		logic [2:0] p;
		reset_to(s);
		chk("clk_sel", (s == CLKSEL_RSVD) ? 2'h0 : s, clk_sel);
		for (int k = 0; k < 3; k++)
		begin
			@(posedge clk);
			div_sel <= k[1:0];
			repeat (8) @(negedge clk);
			f = 0;
			d = 0;
			e = 0;
			p = {full, divc, ext_clk};
			repeat (192)
			begin
				@(negedge clk);
				f += int'(full != p[2]);
				d += int'(divc != p[1]);
				e += int'(ext_clk && !p[0]);
				p = {full, divc, ext_clk};
			end
			if (per != 0)
				e = 192 / per;
			// two toggles of the full clock per source period
			chk("full", 1, f >= 2 * e - 1 && f <= 2 * e + 1);
			chk("div", 1, (d << k) >= f - 4 && (d << k) <= f + 4);
		end
	endtask : clocks
	// one access; st collects every strobe seen, len the strobed cycles
	task automatic access(input logic [31:0] a, input mem_kind_t k, input logic w,
		input sdram_cmd_t c, output logic [2:0] st, output logic fo, output int len);
		int n;
		logic [3:0] sp;
		logic [19:0] ad;
		st = 0;
		sp = 0;
		fo = 0;
		len = 0;
		ad = 0;
		@(posedge clk);
		req <= '{a, k, w};
		cmd <= c;
		req_v <= 1;
		@(negedge clk);
		for (n = 0; n < 64 && rdy !== 1'b1; n++)
			@(negedge clk);
		// a hung handshake counts a mismatch; the run goes on to the report
		if (n == 64)
		begin
			chk("ready", 1, 0);
			return;
		end
		@(posedge clk);
		req_v <= 0;
		repeat (64)
		begin
			@(negedge clk);
			st |= ~stb_n;
			sp |= ~sp_n;
			fo |= ~fifo_n;
			len += int'(stb_n !== 3'h7);
			if (sp_n !== 4'hf)
				ad = addr;
		end
		chk("space", 32'h1 << a[31:28], sp);
		chk("addr", a[19:0], ad);
	endtask : access
	task automatic async_scn;
		logic [2:0] st;
		logic fo;
		int l0, l1;
		wt <= 8'h00;
		access(32'h0000_1234, MEM_ASYNC, 0, '0, st, fo, l0);
		chk("async rd", 3'h6, st);
		access(32'h1002_0abc, MEM_ASYNC, 1, '0, st, fo, l1);
		chk("async wr", 3'h1, st);
		wt <= 8'h18;
		access(32'h2000_0040, MEM_ASYNC, 0, '0, st, fo, l1);
		chk("stretch", 1, l1 >= 24 && l1 > l0);
		wt <= 8'h00;
	endtask : async_scn
	task automatic sdram_scn;
		logic [2:0] st, c;
		logic fo;
		int l;
		for (int i = 0; i < 3; i++)
		begin
			c = 3'h4 >> i;
			access(32'h1000_0100, MEM_SDRAM, c[0], c, st, fo, l);
			chk("sdram pins", {c[1], c[2], c[0]}, st);
		end
	endtask : sdram_scn
	task automatic sync_scn;
		logic [2:0] st;
		logic fo;
		int l;
		@(posedge clk);
		fsel <= 4'h8;
		access(32'h3000_0010, MEM_SYNC, 0, '0, st, fo, l);
		chk("fifo oe", 1, fo);
		chk("read en rd", 3'h6, st);
		access(32'h3000_0018, MEM_SYNC, 1, '0, st, fo, l);
		chk("read en wr", 3'h1, st);
		chk("fifo oe wr", 0, fo);
		@(posedge clk);
		fsel <= 4'h0;
		access(32'h3000_0020, MEM_SYNC, 1, '0, st, fo, l);
		chk("addr strobe", 3'h5, st);
	endtask : sync_scn
	task automatic cke_scn;
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk);
			{pres, cke_req, gp} <= i[2:0];
			repeat (3) @(negedge clk);
			chk("cke", pres ? cke_req : gp, cke);
		end
	endtask : cke_scn
	initial
	begin
		clocks(CLKSEL_EXT, 0);
		clocks(CLKSEL_CPU4, 8);
		clocks(CLKSEL_CPU6, 12);
		clocks(CLKSEL_RSVD, 0);
		reset_to(CLKSEL_CPU4);
		async_scn;
		sdram_scn;
		sync_scn;
		cke_scn;
		final_report;
	end
endmodule : test_ext_mem_pin_control
`default_nettype wire
